// ### verilog/scv_regs.sv
// Video routing, output enable, gain/clamp and blanking register bank with monitor interrupt
// Functional notes
// - VCR audio mono bit selects (L+R)/2
// - Route register holds TV, VCR, RF selectors
// - Output enable bits: 0 Hi-Z, 1 active
// - Chroma I/O bit grounds VCR chroma pin
// - Two-bit RGB gain field, default +6 dB
// - Encoder red/chroma clamp: 0 restore, 1 biased
// - VCR red/chroma clamp defaults to biased
// - Mix bit overrides RF selector with Y/C
// - DC-restore source field, code 11 reserved
// - Auto-startup forces VCR video restore source
// - TV fast blank: 0V, 4V, follow VCR
// - TV slow blank low, mid, high levels
// - VCR slow blank uses same level codes
// - Slow blank direction field, resets zero
// - Slow blank status tracks only input pin
// - Slow blank status codes 00, 01, 11
// - Fast blank status valid when enabled
// - Video monitor set if either input active
// - Fast blank changes interrupt unless masked
// - Slow blank changes interrupt unless masked
// - Video monitor mask resets to one
// - Power-down low resets, blocks register access
// - Address auto-increments, wraps after last register
// - Auto toggle with direction bit pulses interrupt
module scv_regs (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic                 power_down_n,
   input  wire scv_pkg::scv_reg_req_s reg_req,
   output logic [7:0]                reg_rdata,
   input  wire scv_pkg::scv_sense_s  sense,
   output scv_pkg::scv_ctrl_s        ctrl,
   output logic                      int_n
);

   typedef struct packed {
      logic                  auto_startup;
      logic                  vcr_audio_mono_sel;
      scv_pkg::scv_route_s   route;
      scv_pkg::scv_enables_s enables;
      scv_pkg::scv_gain_s    gain;
      scv_pkg::scv_blank_s   blank;
      scv_pkg::scv_monitor_s monitor;
      scv_pkg::scv_mask_s    mask;
      logic [7:0]            addr_ctr;
      logic [7:0]            rdata;
      logic                  pdn_meta;
      logic                  pdn_sync;
      scv_pkg::scv_sense_s   sense_meta;
      scv_pkg::scv_sense_s   sense_sync;
      scv_pkg::scv_ctrl_s    ctrl;
      logic                  int_n;
   } scv_state_s;

   scv_state_s state;
   scv_state_s next_state;

   logic [7:0] rd_value;
   logic       sb_changed;
   logic       fb_changed;
   logic       vid_changed;

   // Read multiplexer at the address counter
   always_comb begin
      rd_value = scv_pkg::BYTE_ZERO;
      case (state.addr_ctr)
         scv_pkg::ADDR_CONTROL: rd_value[scv_pkg::AUTO_BIT] = state.auto_startup;
         scv_pkg::ADDR_ZEROX:   rd_value[scv_pkg::MONO_BIT] = state.vcr_audio_mono_sel;
         scv_pkg::ADDR_ROUTE:   rd_value = state.route;
         scv_pkg::ADDR_ENABLES: rd_value = state.enables;
         scv_pkg::ADDR_GAIN:    rd_value = state.gain;
         scv_pkg::ADDR_BLANK:   rd_value = state.blank;
         scv_pkg::ADDR_MONITOR: rd_value = state.monitor;
         scv_pkg::ADDR_MASK:    rd_value = state.mask;
         default:               rd_value = scv_pkg::BYTE_ZERO;
      endcase
   end

   // Next-state logic
   always_comb begin
      next_state = state;

      // Two-stage synchronisers for pin levels
      next_state.pdn_meta   = power_down_n;
      next_state.pdn_sync   = state.pdn_meta;
      next_state.sense_meta = sense;
      next_state.sense_sync = state.sense_meta;

      // accesses only while power is up
      if (state.pdn_sync) begin
         if (reg_req.addr_load) begin
            next_state.addr_ctr = reg_req.addr;
         end else if (reg_req.wr || reg_req.rd) begin
            if (reg_req.wr) begin
               case (state.addr_ctr)
                  scv_pkg::ADDR_CONTROL: next_state.auto_startup = reg_req.wdata[scv_pkg::AUTO_BIT];
                  scv_pkg::ADDR_ZEROX:   next_state.vcr_audio_mono_sel = reg_req.wdata[scv_pkg::MONO_BIT];
                  scv_pkg::ADDR_ROUTE:   next_state.route = reg_req.wdata;
                  scv_pkg::ADDR_ENABLES: next_state.enables = reg_req.wdata;
                  scv_pkg::ADDR_GAIN: begin
                     next_state.gain = reg_req.wdata;
                     next_state.gain.unused7 = 1'b0;
                  end
                  scv_pkg::ADDR_BLANK:   next_state.blank = reg_req.wdata;
                  scv_pkg::ADDR_MASK: begin
                     next_state.mask = reg_req.wdata;
                     next_state.mask.unused = 4'h0;
                     next_state.mask.unused0 = 1'b0;
                  end
                  default: next_state.addr_ctr = state.addr_ctr;
               endcase
            end else begin
               next_state.rdata = rd_value;
            end
            if (state.addr_ctr >= scv_pkg::ADDR_LAST) begin
               next_state.addr_ctr = scv_pkg::ADDR_FIRST;
            end else begin
               next_state.addr_ctr = state.addr_ctr + scv_pkg::ADDR_STEP;
            end
         end
      end

      // track slow blank only as input
      if (!state.blank.slow_blank_dir_ctrl[0]) begin
         next_state.monitor.vcr_slow_blank_status = state.sense_sync.vcr_slow_blank_code;
      end
      next_state.monitor.vcr_fast_blank_status =
         state.enables.tv_fast_blank_out_en & state.sense_sync.vcr_fast_blank_high;
      next_state.monitor.video_present_status =
         state.sense_sync.tv_video_detect | state.sense_sync.vcr_video_detect;
      next_state.monitor.unused = 4'h0;

      // Monitor change detection on stored status
      // fast blank change
      fb_changed = next_state.monitor.vcr_fast_blank_status != state.monitor.vcr_fast_blank_status;
      sb_changed = next_state.monitor.vcr_slow_blank_status != state.monitor.vcr_slow_blank_status;
      vid_changed = next_state.monitor.video_present_status != state.monitor.video_present_status;

      // Interrupt: one-cycle low pulse on any unmasked monitor change
      next_state.int_n = ~((sb_changed & ~state.mask.slow_blank_irq_mask)
                         | (fb_changed & ~state.mask.fast_blank_irq_mask)
                         | (vid_changed & ~state.mask.video_present_irq_mask)
                         | ((next_state.auto_startup != state.auto_startup)
                            & state.blank.slow_blank_dir_ctrl[1]));

      next_state.ctrl.vcr_audio_mono = state.vcr_audio_mono_sel;
      next_state.ctrl.tv_video_src_sel = state.route.tv_video_src_sel;
      next_state.ctrl.vcr_video_src_sel = state.route.vcr_video_src_sel;
      next_state.ctrl.rf_luma_chroma_mix = state.gain.rf_luma_chroma_mix;
      next_state.ctrl.rf_video_src_sel =
         state.gain.rf_luma_chroma_mix ? 2'b00 : state.route.rf_video_src_sel;
      next_state.ctrl.tv_composite_drive = state.enables.tv_composite_out_en;
      next_state.ctrl.tv_red_chroma_drive = state.enables.tv_red_chroma_out_en;
      next_state.ctrl.tv_green_drive = state.enables.tv_green_out_en;
      next_state.ctrl.tv_blue_drive = state.enables.tv_blue_out_en;
      next_state.ctrl.vcr_composite_drive = state.enables.vcr_composite_out_en;
      next_state.ctrl.tv_fast_blank_drive = state.enables.tv_fast_blank_out_en;
      next_state.ctrl.vcr_chroma_ground = state.enables.vcr_chroma_io_ctrl;
      next_state.ctrl.vcr_chroma_drive =
         state.enables.vcr_chroma_out_en & ~state.enables.vcr_chroma_io_ctrl;
      next_state.ctrl.rgb_gain_sel = state.gain.rgb_gain_sel;
      next_state.ctrl.enc_rc_clamp_mode = state.gain.enc_rc_clamp_mode;
      next_state.ctrl.vcr_rc_clamp_mode = state.gain.vcr_rc_clamp_mode;
      if (state.gain.dc_restore_src_sel == scv_pkg::SCV_DC_RSVD) begin
         next_state.ctrl.dc_restore_src_sel = scv_pkg::SCV_DC_ENC_COMPOSITE;
      end else begin
         next_state.ctrl.dc_restore_src_sel = state.gain.dc_restore_src_sel;
      end
      if (state.auto_startup) begin
         next_state.ctrl.dc_restore_src_sel = scv_pkg::SCV_DC_VCR_VIDEO;
      end
      case (state.blank.tv_fast_blank_level)
         scv_pkg::SCV_FB_HIGH:   next_state.ctrl.tv_fast_blank_high = 1'b1;
         scv_pkg::SCV_FB_FOLLOW: next_state.ctrl.tv_fast_blank_high = state.sense_sync.vcr_fast_blank_high;
         default:                next_state.ctrl.tv_fast_blank_high = 1'b0;
      endcase
      // TV and VCR slow blank, reserved as low
      next_state.ctrl.tv_slow_blank_level =
         (state.blank.tv_slow_blank_level == scv_pkg::SCV_SB_RSVD) ?
         scv_pkg::SCV_SB_LOW : state.blank.tv_slow_blank_level;
      next_state.ctrl.vcr_slow_blank_level =
         (state.blank.vcr_slow_blank_level == scv_pkg::SCV_SB_RSVD) ?
         scv_pkg::SCV_SB_LOW : state.blank.vcr_slow_blank_level;
      next_state.ctrl.vcr_slow_blank_out_en = state.blank.slow_blank_dir_ctrl[0];
      next_state.ctrl.tv_slow_blank_out_en = state.blank.slow_blank_dir_ctrl[1];

      if (!state.pdn_sync) begin
         next_state.auto_startup = scv_pkg::AUTO_RST;
         next_state.vcr_audio_mono_sel = scv_pkg::MONO_RST;
         next_state.route = scv_pkg::ROUTE_RST;
         next_state.enables = scv_pkg::ENABLES_RST;
         next_state.gain = scv_pkg::GAIN_RST;
         next_state.blank = scv_pkg::BLANK_RST;
         next_state.monitor = scv_pkg::MONITOR_RST;
         next_state.mask = scv_pkg::MASK_RST;
         next_state.addr_ctr = scv_pkg::ADDR_FIRST;
         next_state.int_n = 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
         state.auto_startup <= scv_pkg::AUTO_RST;
         state.vcr_audio_mono_sel <= scv_pkg::MONO_RST;
         state.route <= scv_pkg::ROUTE_RST;
         state.enables <= scv_pkg::ENABLES_RST;
         state.gain <= scv_pkg::GAIN_RST;
         state.blank <= scv_pkg::BLANK_RST;
         state.monitor <= scv_pkg::MONITOR_RST;
         state.mask <= scv_pkg::MASK_RST;
         state.int_n <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign ctrl      = state.ctrl;
   assign int_n     = state.int_n;

endmodule : scv_regs

// ### verilog/scv_pkg.sv
// Package: register map, field layouts and control carriers for the video/blanking register bank
package scv_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_CONTROL  = 8'h00;
   localparam logic [7:0] ADDR_ZEROX    = 8'h03;
   localparam logic [7:0] ADDR_ROUTE    = 8'h04;
   localparam logic [7:0] ADDR_ENABLES  = 8'h05;
   localparam logic [7:0] ADDR_GAIN     = 8'h06;
   localparam logic [7:0] ADDR_BLANK    = 8'h07;
   localparam logic [7:0] ADDR_MONITOR  = 8'h08;
   localparam logic [7:0] ADDR_MASK     = 8'h09;
   localparam logic [7:0] ADDR_LAST     = 8'h09;
   localparam logic [7:0] ADDR_FIRST    = 8'h00;
   localparam logic [7:0] ADDR_STEP     = 8'h01;
   localparam logic [7:0] BYTE_ZERO     = 8'h00;

   // Bit positions of the two control bits kept from the audio registers
   localparam int unsigned AUTO_BIT  = 3;
   localparam int unsigned MONO_BIT  = 6;
   localparam logic        AUTO_RST  = 1'b1;
   localparam logic        MONO_RST  = 1'b0;

   // Reset values
   localparam logic [7:0] ROUTE_RST   = 8'h9c;
   localparam logic [7:0] ENABLES_RST = 8'h00;
   localparam logic [7:0] GAIN_RST    = 8'h04;
   localparam logic [7:0] BLANK_RST   = 8'h00;
   localparam logic [7:0] MONITOR_RST = 8'h00;
   localparam logic [7:0] MASK_RST    = 8'h08;

   // Two-bit level codes, separate encodings for fast and slow blanking
   typedef enum logic [1:0] {
      SCV_FB_LOW    = 2'b00,
      SCV_FB_HIGH   = 2'b01,
      SCV_FB_FOLLOW = 2'b10,
      SCV_FB_RSVD   = 2'b11
   } scv_fb_code_e;

   typedef enum logic [1:0] {
      SCV_SB_LOW  = 2'b00,
      SCV_SB_MID  = 2'b01,
      SCV_SB_RSVD = 2'b10,
      SCV_SB_HIGH = 2'b11
   } scv_sb_code_e;

   typedef enum logic [1:0] {
      SCV_DC_ENC_COMPOSITE = 2'b00,
      SCV_DC_ENC_LUMA      = 2'b01,
      SCV_DC_VCR_VIDEO     = 2'b10,
      SCV_DC_RSVD          = 2'b11
   } scv_dc_src_e;

   // Register layouts, MSB first
   typedef struct packed {
      logic [1:0] rf_video_src_sel;
      logic [2:0] vcr_video_src_sel;
      logic [2:0] tv_video_src_sel;
   } scv_route_s;

   typedef struct packed {
      logic vcr_chroma_io_ctrl;
      logic tv_fast_blank_out_en;
      logic vcr_chroma_out_en;
      logic vcr_composite_out_en;
      logic tv_blue_out_en;
      logic tv_green_out_en;
      logic tv_red_chroma_out_en;
      logic tv_composite_out_en;
   } scv_enables_s;

   typedef struct packed {
      logic       unused7;
      logic [1:0] dc_restore_src_sel;
      logic       rf_luma_chroma_mix;
      logic       enc_rc_clamp_mode;
      logic       vcr_rc_clamp_mode;
      logic [1:0] rgb_gain_sel;
   } scv_gain_s;

   typedef struct packed {
      logic [1:0] slow_blank_dir_ctrl;
      logic [1:0] vcr_slow_blank_level;
      logic [1:0] tv_slow_blank_level;
      logic [1:0] tv_fast_blank_level;
   } scv_blank_s;

   typedef struct packed {
      logic [3:0] unused;
      logic       video_present_status;
      logic       vcr_fast_blank_status;
      logic [1:0] vcr_slow_blank_status;
   } scv_monitor_s;

   typedef struct packed {
      logic [3:0] unused;
      logic       video_present_irq_mask;
      logic       fast_blank_irq_mask;
      logic       slow_blank_irq_mask;
      logic       unused0;
   } scv_mask_s;

   // Register access port from the serial engine
   typedef struct packed {
      logic       addr_load;
      logic [7:0] addr;
      logic       wr;
      logic [7:0] wdata;
      logic       rd;
   } scv_reg_req_s;

   // Analog monitor inputs (comparator outputs, asynchronous)
   typedef struct packed {
      logic [1:0] vcr_slow_blank_code;
      logic       vcr_fast_blank_high;
      logic       tv_video_detect;
      logic       vcr_video_detect;
   } scv_sense_s;

   // Controls to the analog switch matrix
   typedef struct packed {
      logic       vcr_audio_mono;
      logic [2:0] tv_video_src_sel;
      logic [2:0] vcr_video_src_sel;
      logic [1:0] rf_video_src_sel;
      logic       rf_luma_chroma_mix;
      logic       tv_composite_drive;
      logic       tv_red_chroma_drive;
      logic       tv_green_drive;
      logic       tv_blue_drive;
      logic       vcr_composite_drive;
      logic       vcr_chroma_drive;
      logic       vcr_chroma_ground;
      logic       tv_fast_blank_drive;
      logic       tv_fast_blank_high;
      logic [1:0] rgb_gain_sel;
      logic       enc_rc_clamp_mode;
      logic       vcr_rc_clamp_mode;
      logic [1:0] dc_restore_src_sel;
      logic [1:0] tv_slow_blank_level;
      logic [1:0] vcr_slow_blank_level;
      logic       tv_slow_blank_out_en;
      logic       vcr_slow_blank_out_en;
   } scv_ctrl_s;

endpackage : scv_pkg

// ### tb/scv_regs_checker.sv
// Port assertions for the video/blanking register bank
module scv_regs_checker (
   input wire logic                  mclk,
   input wire logic                  rst_n,
   input wire logic                  power_down_n,
   input wire scv_pkg::scv_reg_req_s reg_req,
   input wire logic [7:0]            reg_rdata,
   input wire scv_pkg::scv_sense_s   sense,
   input wire scv_pkg::scv_ctrl_s    ctrl,
   input wire logic                  int_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   logic       wr_only;
   logic       pdn_q1;
   logic       pdn_q2;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n || !power_down_n);
   // Shadow of the power-down synchroniser
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pdn_q1 <= 1'b0;
         pdn_q2 <= 1'b0;
      end else begin
         pdn_q1 <= power_down_n;
         pdn_q2 <= pdn_q1;
      end
   end
   // Shadow address counter, wraps after last register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 8'h00;
      end else if (!pdn_q2) begin
         cnt <= 8'h00;
      end else if (reg_req.addr_load) begin
         cnt <= reg_req.addr;
      end else if (reg_req.wr || reg_req.rd) begin
         cnt <= (cnt >= scv_pkg::ADDR_LAST) ? scv_pkg::ADDR_FIRST : cnt + 8'h01;
      end
   end
   assign wr_only = reg_req.wr && !reg_req.addr_load;
   property p_chroma_ground;
      ctrl.vcr_chroma_ground |-> !ctrl.vcr_chroma_drive;
   endproperty
   a_chroma_ground: assert property (p_chroma_ground)
      else $error("VCR chroma pin driven while grounded");
   property p_enables_write;
      logic [7:0] d;
      (wr_only && cnt == scv_pkg::ADDR_ENABLES, d = reg_req.wdata) |-> ##2
         ctrl.tv_composite_drive == d[0] && ctrl.tv_fast_blank_drive == d[6] && ctrl.vcr_chroma_ground == d[7];
   endproperty
   a_enables_write: assert property (p_enables_write)
      else $error("Output drives do not follow enable write");
   property p_gain_write;
      logic [7:0] d;
      (wr_only && cnt == scv_pkg::ADDR_GAIN, d = reg_req.wdata) |-> ##2
         ctrl.rgb_gain_sel == d[1:0] && ctrl.enc_rc_clamp_mode == d[3] && ctrl.vcr_rc_clamp_mode == d[2];
   endproperty
   a_gain_write: assert property (p_gain_write)
      else $error("Gain or clamp does not follow write");
   property p_mono_write;
      logic d;
      (wr_only && cnt == scv_pkg::ADDR_ZEROX, d = reg_req.wdata[scv_pkg::MONO_BIT]) |-> ##2 ctrl.vcr_audio_mono == d;
   endproperty
   a_mono_write: assert property (p_mono_write)
      else $error("Mono select does not follow write");
   property p_rf_mix;
      ctrl.rf_luma_chroma_mix |-> ctrl.rf_video_src_sel == 2'b00;
   endproperty
   a_rf_mix: assert property (p_rf_mix)
      else $error("RF selector active during mixing");
   property p_rsvd_codes;
      ctrl.dc_restore_src_sel != 2'b11 && ctrl.tv_slow_blank_level != 2'b10 && ctrl.vcr_slow_blank_level != 2'b10;
   endproperty
   a_rsvd_codes: assert property (p_rsvd_codes)
      else $error("Reserved code reached the switches");
   property p_int_pulse;
      $fell(int_n) |=> int_n;
   endproperty
   a_int_pulse: assert property (p_int_pulse)
      else $error("Interrupt low longer than one cycle");
   property p_monitor_read;
      (reg_req.rd && !reg_req.wr && !reg_req.addr_load && cnt == scv_pkg::ADDR_MONITOR) |=> reg_rdata[7:4] == 4'h0;
   endproperty
   a_monitor_read: assert property (p_monitor_read)
      else $error("Monitor upper nibble not zero");
   property p_pdn_defaults;
      disable iff (!rst_n) !power_down_n [*6] |-> int_n && ctrl.tv_video_src_sel == 3'b100
         && ctrl.rf_video_src_sel == 2'b10 && !ctrl.tv_composite_drive;
   endproperty
   a_pdn_defaults: assert property (p_pdn_defaults)
      else $error("Defaults not restored in power-down");
   c_enables: cover property (wr_only && cnt == scv_pkg::ADDR_ENABLES);
   c_int: cover property ($fell(int_n));
   c_pdn: cover property (!power_down_n [*6]);
endmodule : scv_regs_checker

bind scv_regs scv_regs_checker scv_regs_checker_i (.mclk(mclk), .rst_n(rst_n), .power_down_n(power_down_n),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .sense(sense), .ctrl(ctrl), .int_n(int_n));

// ### tb/scv_host_model.sv
// Host model issuing register port requests
module scv_host_model (
   input  wire logic             mclk,
   input  wire logic [7:0]       reg_rdata,
   output scv_pkg::scv_reg_req_s reg_req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_req = '0;
   end
   // Load counter; released address shows inverse
   task automatic load(input logic [7:0] a);
      @(negedge mclk);
      reg_req.addr_load <= 1'b1;
      reg_req.addr      <= a;
      @(negedge mclk);
      reg_req.addr_load <= 1'b0;
      reg_req.addr      <= ~a;
   endtask : load
   // Write one byte, counter steps
   task automatic put(input logic [7:0] d);
      @(negedge mclk);
      reg_req.wr    <= 1'b1;
      reg_req.wdata <= d;
      @(negedge mclk);
      reg_req.wr    <= 1'b0;
      reg_req.wdata <= ~d;
   endtask : put
   // Read one byte, counter steps
   task automatic get(output logic [7:0] d);
      @(negedge mclk);
      reg_req.rd <= 1'b1;
      @(negedge mclk);
      reg_req.rd <= 1'b0;
      d = reg_rdata;
   endtask : get
endmodule : scv_host_model

// ### tb/scv_regs_tb_top.sv
// Self-checking testbench for the video/blanking register bank
module scv_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  mclk;
   logic                  rst_n;
   logic                  power_down_n;
   scv_pkg::scv_reg_req_s reg_req;
   logic [7:0]            reg_rdata;
   scv_pkg::scv_sense_s   sense;
   scv_pkg::scv_ctrl_s    ctrl;
   logic                  int_n;
   int                    error_cnt = 0;
   int                    compares = 0;
   int                    int_cnt = 0;
   int                    int_mark = 0;
   int                    k;
   logic [1:0]            e;
   logic [7:0]            v;
   logic [7:0]            rst_tab [7] = '{8'h9c, 8'h00, 8'h04, 8'h00, 8'h00, 8'h08, 8'h08};
   scv_regs scv_regs_i (.mclk(mclk), .rst_n(rst_n), .power_down_n(power_down_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .sense(sense), .ctrl(ctrl), .int_n(int_n));
   scv_host_model scv_host_model_i (.mclk(mclk), .reg_rdata(reg_rdata), .reg_req(reg_req));
   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Count interrupt pulses
   always @(negedge mclk) begin
      if (int_n === 1'b0) int_cnt++;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      scv_host_model_i.load(a);
      scv_host_model_i.put(d);
      @(negedge mclk);
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      scv_host_model_i.load(a);
      scv_host_model_i.get(d);
      check(d, exp);
   endtask : rreg
   task automatic pulses(input int exp);
      repeat (8) @(negedge mclk);
      check(8'(int_cnt - int_mark), 8'(exp));
      int_mark = int_cnt;
   endtask : pulses
   task automatic print_verdict;
      $display("Counts: %0d compares, %0d errors", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      print_verdict();
   end
   // Test sequence
   initial begin
      rst_n = 1'b0;
      power_down_n = 1'b1;
      sense = '0;
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      scv_host_model_i.load(scv_pkg::ADDR_ROUTE);
      for (k = 0; k < 7; k++) begin
         scv_host_model_i.get(v);
         check(v, rst_tab[k]);
      end
      check({ctrl.tv_video_src_sel, ctrl.vcr_video_src_sel, ctrl.rf_video_src_sel}, 8'h8e);
      check({5'h0, ctrl.dc_restore_src_sel, ctrl.vcr_rc_clamp_mode}, 8'h05);
      $display("Test reset values done");
      wreg(scv_pkg::ADDR_ROUTE, 8'h6b);
      rreg(scv_pkg::ADDR_ROUTE, 8'h6b);
      check({ctrl.tv_video_src_sel, ctrl.vcr_video_src_sel, ctrl.rf_video_src_sel}, 8'h75);
      wreg(scv_pkg::ADDR_GAIN, 8'hff);
      rreg(scv_pkg::ADDR_GAIN, 8'h7f);
      check({6'h0, ctrl.rf_luma_chroma_mix, ctrl.rf_video_src_sel != 2'b00}, 8'h02);
      wreg(scv_pkg::ADDR_MONITOR, 8'hff);
      rreg(scv_pkg::ADDR_MONITOR, 8'h00);
      wreg(scv_pkg::ADDR_MASK, 8'hff);
      rreg(scv_pkg::ADDR_MASK, 8'h0e);
      wreg(scv_pkg::ADDR_ENABLES, 8'h81);
      check({6'h0, ctrl.vcr_chroma_ground, ctrl.vcr_chroma_drive}, 8'h02);
      wreg(scv_pkg::ADDR_ENABLES, 8'h7f);
      check({1'b0, ctrl.tv_composite_drive, ctrl.tv_red_chroma_drive, ctrl.tv_green_drive, ctrl.tv_blue_drive,
         ctrl.vcr_composite_drive, ctrl.vcr_chroma_drive, ctrl.tv_fast_blank_drive}, 8'h7f);
      wreg(scv_pkg::ADDR_ENABLES, 8'h00);
      check({7'h0, ctrl.tv_composite_drive}, 8'h00);
      $display("Test readback and enables done");
      wreg(scv_pkg::ADDR_CONTROL, 8'h00);
      for (k = 0; k < 4; k++) begin
         e = (k == 3) ? 2'b00 : k[1:0];
         wreg(scv_pkg::ADDR_GAIN, {1'b0, k[1:0], 1'b0, k[0], 1'b0, k[1:0]});
         check({2'h0, ctrl.dc_restore_src_sel, ctrl.enc_rc_clamp_mode, 1'b0, ctrl.rgb_gain_sel},
            {2'h0, e, k[0], 1'b0, k[1:0]});
      end
      wreg(scv_pkg::ADDR_CONTROL, 8'h08);
      check({6'h0, ctrl.dc_restore_src_sel}, 8'h02);
      wreg(scv_pkg::ADDR_ZEROX, 8'h40);
      check({7'h0, ctrl.vcr_audio_mono}, 8'h01);
      for (k = 0; k < 4; k++) begin
         e = (k == 2) ? 2'b00 : k[1:0];
         wreg(scv_pkg::ADDR_BLANK, {2'b00, k[1:0], k[1:0], k[1:0]});
         rreg(scv_pkg::ADDR_BLANK, {2'b00, k[1:0], k[1:0], k[1:0]});
         check({2'h0, ctrl.tv_slow_blank_level, ctrl.vcr_slow_blank_level, 1'b0, ctrl.tv_fast_blank_high},
            {2'h0, e, e, 1'b0, k == 1});
      end
      sense.vcr_fast_blank_high = 1'b1;
      wreg(scv_pkg::ADDR_BLANK, 8'h02);
      repeat (4) @(negedge mclk);
      check({7'h0, ctrl.tv_fast_blank_high}, 8'h01);
      $display("Test codes done");
      int_mark = int_cnt;
      wreg(scv_pkg::ADDR_MASK, 8'h00);
      sense.tv_video_detect = 1'b1;
      pulses(1);
      rreg(scv_pkg::ADDR_MONITOR, 8'h08);
      wreg(scv_pkg::ADDR_MASK, 8'h08);
      sense.tv_video_detect = 1'b0;
      pulses(0);
      wreg(scv_pkg::ADDR_ENABLES, 8'h40);
      pulses(1);
      rreg(scv_pkg::ADDR_MONITOR, 8'h04);
      wreg(scv_pkg::ADDR_MASK, 8'h0c);
      sense.vcr_fast_blank_high = 1'b0;
      pulses(0);
      sense.vcr_slow_blank_code = 2'b01;
      pulses(1);
      rreg(scv_pkg::ADDR_MONITOR, 8'h01);
      wreg(scv_pkg::ADDR_BLANK, 8'h40);
      check({6'h0, ctrl.tv_slow_blank_out_en, ctrl.vcr_slow_blank_out_en}, 8'h01);
      sense.vcr_slow_blank_code = 2'b11;
      pulses(0);
      rreg(scv_pkg::ADDR_MONITOR, 8'h01);
      wreg(scv_pkg::ADDR_BLANK, 8'h00);
      pulses(1);
      rreg(scv_pkg::ADDR_MONITOR, 8'h03);
      wreg(scv_pkg::ADDR_MASK, 8'h0e);
      sense.vcr_slow_blank_code = 2'b00;
      pulses(0);
      wreg(scv_pkg::ADDR_BLANK, 8'h80);
      check({6'h0, ctrl.tv_slow_blank_out_en, ctrl.vcr_slow_blank_out_en}, 8'h02);
      pulses(0);
      wreg(scv_pkg::ADDR_CONTROL, 8'h00);
      pulses(1);
      $display("Test monitor and interrupt done");
      power_down_n = 1'b0;
      wreg(scv_pkg::ADDR_ROUTE, 8'h11);
      repeat (2) @(negedge mclk);
      power_down_n = 1'b1;
      repeat (4) @(negedge mclk);
      rreg(scv_pkg::ADDR_ROUTE, 8'h9c);
      rreg(scv_pkg::ADDR_MASK, 8'h08);
      $display("Test power-down done");
      print_verdict();
   end
endmodule : scv_regs_tb_top
